// *** hw/nic_top.sv ***
// Network interface controller: send, receive and pause handling.
`default_nettype none
// Function
// [R1] An interrupt is raised when a send finishes or a packet is stored.
// [R2] Reading a completion strobe removes one pending completion.
// [R3] Software supplies send requests and receive addresses by writes.
// [R4] The reader takes send requests and fetches flits from memory.
// [R5] Out-of-order read answers are reordered and sent in issue order.
// [R6] An arbiter shares the port with a tap-in, or passes data through.
// [R7] The receive buffer drops whole packets when it runs out of room.
// [R8] A tap diverts packets by header to a tap-out, else to the writer.
// [R9] The writer stores data first and only then counts a completion.
// [R10] The pause unit watches received traffic and buffer occupancy at the port.
// [R11] A filling receive buffer makes the unit send a pause frame.
// [R12] A received pause frame blocks the controller's own sends.
// [R13] The receive buffer depth is a parameter in 64-bit flits.
// [R14] A build flag selects the pause unit; off means no pausing at all.
// [R15] The interrupt stays high while any completion is unread.
// [R16] A blocked send finishes its packet and resumes after the pause.
module nic_top
   import nic_pkg::*;
#(
   parameter int unsigned rx_buffer_depth_flits = NIC_RX_DEPTH_DEF,
   parameter bit          flow_control_present  = 1'b1,
   parameter bit          tap_in_present        = 1'b0,
   parameter bit          tap_out_present       = 1'b0,
   parameter logic [47:0] tap_out_mac           = NIC_TAP_MAC_DEF
) (
   input  wire logic          sys_clk,
   input  wire logic          srst,
   input  wire logic          send_req_valid,
   input  wire nic_send_req_s send_req,
   output logic               send_req_ready,
   input  wire logic          recv_addr_valid,
   input  wire logic [31:0]   recv_addr,
   output logic               recv_addr_ready,
   input  wire logic          send_comp_read,
   input  wire logic          recv_comp_read,
   output logic [NIC_COMP_W-1:0] send_comp_count,
   output logic [NIC_COMP_W-1:0] recv_comp_count,
   output logic               irq,
   output logic               rd_req_valid,
   output logic [31:0]        rd_req_addr,
   output logic [NIC_TAG_W-1:0] rd_req_tag,
   input  wire logic          rd_req_ready,
   input  wire logic          rd_resp_valid,
   input  wire logic [NIC_TAG_W-1:0] rd_resp_tag,
   input  wire logic [63:0]   rd_resp_data,
   output logic               wr_req_valid,
   output logic [31:0]        wr_req_addr,
   output logic [63:0]        wr_req_data,
   input  wire logic          wr_req_ready,
   output logic               net_tx_valid,
   output nic_flit_s          net_tx_flit,
   input  wire logic          net_tx_ready,
   input  wire logic          net_rx_valid,
   input  wire nic_flit_s     net_rx_flit,
   input  wire logic          tap_in_valid,
   input  wire nic_flit_s     tap_in_flit,
   output logic               tap_in_ready,
   output logic               tap_out_valid,
   output nic_flit_s          tap_out_flit,
   input  wire logic          tap_out_ready
);
   localparam int unsigned AW = $clog2(rx_buffer_depth_flits);
   localparam logic [AW:0] DEPTH_P = (AW+1)'(rx_buffer_depth_flits); // R13
   localparam logic [AW:0] HIGH_P  = (AW+1)'(rx_buffer_depth_flits*3/4);
   localparam logic [AW:0] LOW_P   = (AW+1)'(rx_buffer_depth_flits/2);

   // Send reader and reservation queue state.
   logic [8:0]  rd_left;
   logic [31:0] rd_addr_cur;
   logic [NIC_TAG_W-1:0] iss_ptr, rq_head;
   logic [NIC_TAG_W:0]   inflight;
   logic [NIC_RQ_DEPTH-1:0] slot_valid, slot_last;
   logic [63:0] slot_data [NIC_RQ_DEPTH];
   // Outbound arbiter state.
   nic_owner_e  owner, cur, pick, next_owner;
   logic        out_from_nic, tap_hold_valid, pause_req, pause_armed;
   nic_flit_s   tap_hold, src_flit;
   logic [2:0]  pause_idx;
   logic [18:0] pause_timer;
   // Receive buffer, tap and writer state.
   logic [AW:0] wr_ptr, commit_ptr, rd_ptr;
   logic        dropping, buf_valid, rx_first, divert_reg, rx_addr_have;
   logic [31:0] wr_cur_addr;
   logic        wr_last;
   nic_flit_s   buf_flit;
   logic [1:0]  rx_idx;
   logic        pmatch0, pmatch1;

   // Send side decode.
   wire req_take  = send_req_valid & send_req_ready;
   wire iss_free  = ~rd_req_valid | rd_req_ready;
   wire issue     = iss_free & (rd_left != 9'h000)
                    & (inflight != (NIC_TAG_W+1)'(NIC_RQ_DEPTH));
   wire head_valid = slot_valid[rq_head];
   wire take      = ~net_tx_valid | net_tx_ready;
   wire nic_ok    = head_valid & (pause_timer == NIC_TIMER_RST);
   wire tap_ok    = tap_in_present & tap_hold_valid;
   wire send_done = net_tx_valid & net_tx_ready & net_tx_flit.last
                    & out_from_nic;

   // Pause frame flits, built from the fixed address and quanta.
   function automatic nic_flit_s pause_flit(input logic [2:0] idx);
      nic_flit_s f;
      f.data = 64'h0000_0000_0000_0000;
      f.last = (idx == NIC_PAUSE_LAST);
      case (idx)
         3'h0: f.data = {NIC_SRC_MAC[15:0], NIC_PAUSE_MAC};
         3'h1: f.data = {NIC_PAUSE_TYPOP, NIC_SRC_MAC[47:16]};
         3'h2: f.data = {48'h0000_0000_0000, NIC_PAUSE_QUANTA[7:0],
                         NIC_PAUSE_QUANTA[15:8]};
         default: f.data = 64'h0000_0000_0000_0000;
      endcase
      return f;
   endfunction : pause_flit

   // Arbiter choice: pause frame first, then own data, then tap-in.
   assign pick = pause_req ? NIC_OWN_PAUSE                          // R11
               : nic_ok    ? NIC_OWN_NIC                            // R12
               : tap_ok    ? NIC_OWN_TAP : NIC_OWN_IDLE;            // R6
   assign cur  = (owner != NIC_OWN_IDLE) ? owner : pick;            // R16
   assign src_flit = (cur == NIC_OWN_PAUSE) ? pause_flit(pause_idx)
                   : (cur == NIC_OWN_TAP)   ? tap_hold
                   : nic_flit_s'{slot_data[rq_head], slot_last[rq_head]};
   wire src_valid = (cur == NIC_OWN_PAUSE)
                    | (cur == NIC_OWN_TAP & tap_hold_valid)
                    | (cur == NIC_OWN_NIC & head_valid);
   wire fire      = take & src_valid & (cur != NIC_OWN_IDLE);
   wire fire_nic  = fire & (cur == NIC_OWN_NIC);
   assign next_owner = fire ? (src_flit.last ? NIC_OWN_IDLE : cur) : owner;

   // Reader: accept a request and issue one tagged read per flit.
   always_ff @(posedge sys_clk) begin // R4
      if (srst) begin
         rd_left <= 9'h000;
         send_req_ready <= 1'b0;
         rd_req_valid <= 1'b0;
         iss_ptr <= 3'h0;
      end else begin
         send_req_ready <= (rd_left == 9'h000) & ~req_take & ~send_req_ready;
         if (req_take) begin
            rd_left <= (send_req.flits == 8'h00) ? 9'h100
                     : {1'b0, send_req.flits};
            rd_addr_cur <= send_req.addr;
         end else if (issue) begin
            rd_left <= rd_left - 9'h001;
            rd_addr_cur <= rd_addr_cur + NIC_FLIT_BYTES;
            rd_req_addr <= rd_addr_cur;
            rd_req_tag <= iss_ptr;
            iss_ptr <= iss_ptr + 3'h1;
         end
         if (iss_free) rd_req_valid <= issue;
      end
   end

   // Reservation queue: answers land by tag, leave from the head.
   always_ff @(posedge sys_clk) begin // R5
      if (srst) begin
         slot_valid <= '0;
         rq_head <= 3'h0;
         inflight <= 4'h0;
      end else begin
         if (rd_resp_valid) begin
            slot_valid[rd_resp_tag] <= 1'b1;
            slot_data[rd_resp_tag] <= rd_resp_data;
         end
         if (issue & ~req_take) slot_last[iss_ptr] <= (rd_left == 9'h001);
         if (fire_nic) begin
            slot_valid[rq_head] <= 1'b0;
            rq_head <= rq_head + 3'h1;
         end
         inflight <= inflight + {3'h0, issue & ~req_take} - {3'h0, fire_nic};
      end
   end

   // Output stage and port ownership.
   always_ff @(posedge sys_clk) begin // R6
      if (srst) begin
         net_tx_valid <= 1'b0;
         owner <= NIC_OWN_IDLE;
         out_from_nic <= 1'b0;
      end else begin
         owner <= next_owner;
         if (take) net_tx_valid <= fire;
         if (fire) begin
            net_tx_flit <= src_flit;
            out_from_nic <= (cur == NIC_OWN_NIC);
         end
      end
   end

   // One-entry tap-in holding register keeps tap_in_ready a flop.
   wire tap_fire = fire & (cur == NIC_OWN_TAP);
   wire tap_load = tap_in_valid & tap_in_ready;
   wire next_hold_valid = tap_load | (tap_hold_valid & ~tap_fire);
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         tap_hold_valid <= 1'b0;
         tap_in_ready <= 1'b0;
      end else begin
         tap_hold_valid <= next_hold_valid;
         tap_in_ready <= tap_in_present & ~next_hold_valid;
         if (tap_load) tap_hold <= tap_in_flit;
      end
   end

   // Receive buffer pointers with whole-packet drop.
   wire [AW:0] occ  = wr_ptr - rd_ptr;
   wire full        = (occ == DEPTH_P);
   wire rx_write    = net_rx_valid & ~dropping & ~full;
   wire buf_take;
   wire rd_en       = (rd_ptr != commit_ptr) & (~buf_valid | buf_take);
   always_ff @(posedge sys_clk) begin // R7
      if (srst) begin
         wr_ptr <= '0;
         commit_ptr <= '0;
         rd_ptr <= '0;
         dropping <= 1'b0;
         buf_valid <= 1'b0;
      end else begin
         if (net_rx_valid & dropping) begin
            dropping <= ~net_rx_flit.last;
         end else if (net_rx_valid & full) begin
            wr_ptr <= commit_ptr;
            dropping <= ~net_rx_flit.last;
         end else if (rx_write) begin
            wr_ptr <= wr_ptr + 1'b1;
            if (net_rx_flit.last) commit_ptr <= wr_ptr + 1'b1;
         end
         if (rd_en) rd_ptr <= rd_ptr + 1'b1;
         if (rd_en | buf_take) buf_valid <= rd_en;
      end
   end

   nic_rx_mem #(.DEPTH(rx_buffer_depth_flits), .AW(AW)) u_mem (
      .sys_clk (sys_clk),
      .wr_en   (rx_write),
      .wr_addr (wr_ptr[AW-1:0]),
      .wr_flit (net_rx_flit),
      .rd_en   (rd_en),
      .rd_addr (rd_ptr[AW-1:0]),
      .rd_flit (buf_flit)
   );

   // Tap decision on the first flit, by destination address.
   wire divert   = rx_first ? (tap_out_present
                   & (buf_flit.data[47:0] == tap_out_mac)) : divert_reg; // R8
   wire wr_free  = ~wr_req_valid | wr_req_ready;
   wire tapo_free = ~tap_out_valid | tap_out_ready;
   wire to_wr    = buf_valid & ~divert & rx_addr_have & wr_free;
   wire to_tap   = buf_valid & divert & tapo_free;
   assign buf_take = to_wr | to_tap;
   wire recv_done = wr_req_valid & wr_req_ready & wr_last;
   always_ff @(posedge sys_clk) begin // R9
      if (srst) begin
         rx_first <= 1'b1;
         divert_reg <= 1'b0;
         rx_addr_have <= 1'b0;
         recv_addr_ready <= 1'b0;
         wr_req_valid <= 1'b0;
         wr_last <= 1'b0;
         tap_out_valid <= 1'b0;
      end else begin
         if (buf_take) begin
            rx_first <= buf_flit.last;
            divert_reg <= divert;
         end
         recv_addr_ready <= ~rx_addr_have & ~recv_addr_ready;
         if (recv_addr_valid & recv_addr_ready) begin
            wr_cur_addr <= recv_addr;
            rx_addr_have <= 1'b1;
         end else if (to_wr) begin
            wr_cur_addr <= wr_cur_addr + NIC_FLIT_BYTES;
            if (buf_flit.last) rx_addr_have <= 1'b0;
         end
         if (wr_free) wr_req_valid <= to_wr;
         if (to_wr) begin
            wr_req_addr <= wr_cur_addr;
            wr_req_data <= buf_flit.data;
            wr_last <= buf_flit.last;
         end
         if (tapo_free) tap_out_valid <= to_tap;
         if (to_tap) tap_out_flit <= buf_flit;
      end
   end

   // Pause unit: request a frame as the buffer fills, honour received ones.
   wire rx_pause_seen = net_rx_valid & (rx_idx == 2'h2) & pmatch0 & pmatch1;
   wire [15:0] rx_quanta = {net_rx_flit.data[7:0], net_rx_flit.data[15:8]};
   always_ff @(posedge sys_clk) begin // R10
      if (srst) begin
         pause_req <= 1'b0;
         pause_armed <= 1'b1;
         pause_idx <= 3'h0;
         pause_timer <= NIC_TIMER_RST;
         rx_idx <= 2'h0;
         pmatch0 <= 1'b0;
         pmatch1 <= 1'b0;
      end else begin
         // A new request set below outweighs this end-of-frame clear.
         if (fire & (cur == NIC_OWN_PAUSE)) begin
            pause_idx <= pause_idx + 3'h1;
            if (pause_idx == NIC_PAUSE_LAST) pause_req <= 1'b0;
         end
         if (occ < LOW_P) pause_armed <= 1'b1;
         if (flow_control_present & pause_armed & (occ >= HIGH_P)) begin // R14
            pause_req <= 1'b1; // R11
            pause_armed <= 1'b0;
         end
         if (net_rx_valid) begin
            rx_idx <= net_rx_flit.last ? 2'h0
                    : (rx_idx == 2'h3) ? rx_idx : rx_idx + 2'h1;
            if (rx_idx == 2'h0)
               pmatch0 <= (net_rx_flit.data[47:0] == NIC_PAUSE_MAC);
            if (rx_idx == 2'h1)
               pmatch1 <= (net_rx_flit.data[63:32] == NIC_PAUSE_TYPOP);
         end
         if (flow_control_present & rx_pause_seen) // R12
            pause_timer <= {rx_quanta, 3'b000};
         else if (pause_timer != NIC_TIMER_RST)
            pause_timer <= pause_timer - 19'h0_0001; // R16
      end
   end

   // Completion counters; a completion and a read in one cycle both count, and a read at zero is ignored.
   wire [NIC_COMP_W-1:0] next_send = send_comp_count + {3'h0, send_done}
      - {3'h0, send_comp_read & (send_comp_count != NIC_COMP_RST)}; // R2
   wire [NIC_COMP_W-1:0] next_recv = recv_comp_count + {3'h0, recv_done}
      - {3'h0, recv_comp_read & (recv_comp_count != NIC_COMP_RST)};
   always_ff @(posedge sys_clk) begin // R1
      if (srst) begin
         send_comp_count <= NIC_COMP_RST;
         recv_comp_count <= NIC_COMP_RST;
         irq <= 1'b0;
      end else begin
         send_comp_count <= next_send;
         recv_comp_count <= next_recv;
         irq <= (next_send != NIC_COMP_RST)
                | (next_recv != NIC_COMP_RST); // R15
      end
   end

   a_irq_level: assert property (@(posedge sys_clk) disable iff (srst) // R15
      irq == ((send_comp_count != 4'h0) | (recv_comp_count != 4'h0)))
      else $error("irq does not follow pending completions");
   a_read_clears: assert property (@(posedge sys_clk) disable iff (srst) // R2
      send_comp_read & ~send_done & (send_comp_count != 4'h0)
      |=> send_comp_count == $past(send_comp_count) - 4'h1)
      else $error("completion read did not remove one completion");
   a_send_irq: assert property (@(posedge sys_clk) disable iff (srst) // R1
      send_done |=> irq)
      else $error("finished send raised no interrupt");
   a_queue_order: assert property (@(posedge sys_clk) disable iff (srst) // R5
      fire_nic |=> rq_head == $past(rq_head) + 3'h1
                   && !slot_valid[$past(rq_head)])
      else $error("reservation queue left issue order");
   a_drop_whole: assert property (@(posedge sys_clk) disable iff (srst) // R7
      net_rx_valid & full & ~dropping & ~net_rx_flit.last
      |=> dropping && wr_ptr == commit_ptr)
      else $error("partial packet kept in receive buffer");
   a_pause_block: assert property (@(posedge sys_clk) disable iff (srst) // R12
      (pause_timer != 19'h0 && owner != NIC_OWN_NIC) |=> owner != NIC_OWN_NIC)
      else $error("paused transmit path started a packet");
   a_pause_frame: assert property (@(posedge sys_clk) disable iff (srst) // R11
      (pause_req && owner == NIC_OWN_IDLE && take && pause_idx == 3'h0)
      |=> net_tx_valid && net_tx_flit.data[47:0] == NIC_PAUSE_MAC)
      else $error("pause frame not sent first");
   a_flow_off: assert property (@(posedge sys_clk) disable iff (srst) // R14
      !flow_control_present |-> pause_timer == 19'h0 && !pause_req)
      else $error("pausing active without a pause unit");
   a_writer_addr: assert property (@(posedge sys_clk) disable iff (srst) // R9
      to_wr |-> rx_addr_have ##1 wr_req_valid)
      else $error("write issued without a supplied address");
   a_no_tap_out: assert property (@(posedge sys_clk) disable iff (srst) // R8
      !tap_out_present |-> !tap_out_valid)
      else $error("packet diverted with no tap-out configured");
endmodule : nic_top
`default_nettype wire

// *** hw/nic_pkg.sv ***
// Shared types and constants of the network interface controller.
`default_nettype none
package nic_pkg;
   // One 64-bit flit with its end-of-packet marker.
   typedef struct packed {
      logic [63:0] data;
      logic        last;
   } nic_flit_s;

   // Send request: byte address of the packet and its length in flits.
   typedef struct packed {
      logic [31:0] addr;
      logic [7:0]  flits;
   } nic_send_req_s;

   // Owner of the outbound port while a packet is in progress.
   typedef enum logic [1:0] {
      NIC_OWN_IDLE  = 2'b00,
      NIC_OWN_NIC   = 2'b01,
      NIC_OWN_TAP   = 2'b10,
      NIC_OWN_PAUSE = 2'b11
   } nic_owner_e;

   localparam int unsigned NIC_RX_DEPTH_DEF = 64;
   localparam int unsigned NIC_RQ_DEPTH     = 8;
   localparam int unsigned NIC_TAG_W        = 3;
   localparam int unsigned NIC_COMP_W       = 4;
   localparam logic [31:0] NIC_FLIT_BYTES   = 32'h0000_0008;
   localparam logic [2:0]  NIC_PAUSE_LAST   = 3'h7;
   localparam logic [15:0] NIC_PAUSE_QUANTA = 16'h0100;
   localparam int unsigned NIC_QUANTA_SHIFT = 3;
   localparam logic [47:0] NIC_PAUSE_MAC    = 48'h0100_00C2_8001;
   localparam logic [47:0] NIC_SRC_MAC      = 48'h0100_0000_0002;
   localparam logic [47:0] NIC_TAP_MAC_DEF  = 48'h0200_0000_0002;
   localparam logic [31:0] NIC_PAUSE_TYPOP  = 32'h0100_0888;
   localparam logic [18:0] NIC_TIMER_RST    = 19'h0_0000;
   localparam logic [NIC_COMP_W-1:0] NIC_COMP_RST = 4'h0;
endpackage : nic_pkg
`default_nettype wire

// *** hw/nic_rx_mem.sv ***
// Receive packet buffer storage with a registered read port.
`default_nettype none
module nic_rx_mem
   import nic_pkg::*;
#(
   parameter int unsigned DEPTH = NIC_RX_DEPTH_DEF,
   parameter int unsigned AW    = 6
) (
   input  wire logic      sys_clk,
   input  wire logic      wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire nic_flit_s wr_flit,
   input  wire logic      rd_en,
   input  wire logic [AW-1:0] rd_addr,
   output nic_flit_s      rd_flit
);
   nic_flit_s mem [DEPTH];

   // Write port; the array itself holds no reset.
   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_flit;
      end
   end

   // Read data leave through a register one cycle after the request.
   always_ff @(posedge sys_clk) begin
      if (rd_en) begin
         rd_flit <= mem[rd_addr];
      end
   end
endmodule : nic_rx_mem
`default_nettype wire

// *** dv/nic_far_model.sv ***
// Far side model: a slow memory that answers the newest pending read first, and a sink.
`default_nettype none
module nic_far_model
   import nic_pkg::*;
(
   input  wire logic                 sys_clk,
   input  wire logic                 rd_req_valid,
   input  wire logic [31:0]          rd_req_addr,
   input  wire logic [NIC_TAG_W-1:0] rd_req_tag,
   output logic                      rd_req_ready,
   output logic                      rd_resp_valid,
   output logic [NIC_TAG_W-1:0]      rd_resp_tag,
   output logic [63:0]               rd_resp_data,
   input  wire logic                 wr_req_valid,
   input  wire logic [31:0]          wr_req_addr,
   input  wire logic [63:0]          wr_req_data,
   output logic                      wr_req_ready,
   input  wire logic                 net_tx_valid,
   input  wire nic_flit_s            net_tx_flit,
   output logic                      net_tx_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [34:0] pend[$], ent;
   logic [95:0] wr_q[$];
   nic_flit_s   tx_q[$];
   logic        tog = 1'b0;
   // Readies toggle, so the far side stalls every other cycle.
   always @(posedge sys_clk) begin
      tog <= ~tog;
      rd_req_ready <= tog;
      wr_req_ready <= ~tog;
      net_tx_ready <= tog;
      if (rd_req_valid && rd_req_ready) begin
         pend.push_back({rd_req_tag, rd_req_addr});
      end
      // The newest read is answered first; idle data keeps changing.
      if (tog && pend.size() > 0) begin
         ent = pend.pop_back();
         rd_resp_valid <= 1'b1;
         rd_resp_tag <= ent[34:32];
         rd_resp_data <= {ent[31:0], ~ent[31:0]};
      end else begin
         rd_resp_valid <= 1'b0;
         rd_resp_data <= ~rd_resp_data;
      end
      if (wr_req_valid && wr_req_ready) begin
         wr_q.push_back({wr_req_addr, wr_req_data});
      end
      if (net_tx_valid && net_tx_ready) begin
         tx_q.push_back(net_tx_flit);
      end
   end
endmodule : nic_far_model
`default_nettype wire

// *** dv/nic_top_bench.sv ***
// Self-checking bench of the network interface controller.
`default_nettype none
module nic_top_bench
   import nic_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic          sys_clk = 1'b0, srst = 1'b1, net_rx_valid = 1'b0;
   logic          send_req_valid = 1'b0, recv_addr_valid = 1'b0;
   logic          send_comp_read = 1'b0, recv_comp_read = 1'b0;
   logic [31:0]   recv_addr = 32'h0000_0000, rd_req_addr, wr_req_addr;
   nic_send_req_s send_req = '0;
   nic_flit_s     net_rx_flit = '0, net_tx_flit, f;
   logic          send_req_ready, recv_addr_ready, irq, rd_req_valid;
   logic          rd_req_ready, rd_resp_valid, wr_req_valid, wr_req_ready;
   logic          net_tx_valid, net_tx_ready;
   logic [NIC_COMP_W-1:0] send_comp_count, recv_comp_count;
   logic [NIC_TAG_W-1:0]  rd_req_tag, rd_resp_tag;
   logic [63:0]   rd_resp_data, wr_req_data;
   int            failures = 0, comparisons = 0;
   // A 40 ns clock.
   always #20 sys_clk = ~sys_clk;
   // Receive buffer cut down to 16 flits so that it fills quickly.
   nic_top #(.rx_buffer_depth_flits(16)) uut (
      .sys_clk, .srst, .send_req_valid, .send_req, .send_req_ready,
      .recv_addr_valid, .recv_addr, .recv_addr_ready, .send_comp_read,
      .recv_comp_read, .send_comp_count, .recv_comp_count, .irq,
      .rd_req_valid, .rd_req_addr, .rd_req_tag, .rd_req_ready,
      .rd_resp_valid, .rd_resp_tag, .rd_resp_data, .wr_req_valid,
      .wr_req_addr, .wr_req_data, .wr_req_ready, .net_tx_valid,
      .net_tx_flit, .net_tx_ready, .net_rx_valid, .net_rx_flit,
      .tap_in_valid(1'b0), .tap_in_flit('0), .tap_in_ready(),
      .tap_out_valid(), .tap_out_flit(), .tap_out_ready(1'b1));
   // Memory and network partner.
   nic_far_model far (
      .sys_clk, .rd_req_valid, .rd_req_addr, .rd_req_tag, .rd_req_ready,
      .rd_resp_valid, .rd_resp_tag, .rd_resp_data, .wr_req_valid,
      .wr_req_addr, .wr_req_data, .wr_req_ready, .net_tx_valid,
      .net_tx_flit, .net_tx_ready);
   // Compares one value and counts the result.
   task automatic check(string w, logic [95:0] s, logic [95:0] e);
      comparisons++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", w, e, s);
      end
   endtask : check
   // Prints the counts and the verdict, then stops.
   task automatic finish_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test
   // Waits, bounded, until a partner queue holds n entries.
   task automatic wait_q(bit wr, int n);
      repeat (9000) if ((wr ? far.wr_q.size() : far.tx_q.size()) < n)
         @(posedge sys_clk);
   endtask : wait_q
   // Offers a receive address or a send request, held until taken.
   task automatic offer(bit rx, logic [31:0] a, logic [7:0] n);
      @(posedge sys_clk);
      recv_addr_valid <= rx;
      send_req_valid <= !rx;
      recv_addr <= a;
      send_req <= '{addr: a, flits: n};
      @(posedge sys_clk);
      repeat (500) if ((rx ? recv_addr_ready : send_req_ready) !== 1'b1)
         @(posedge sys_clk);
      check("offer taken", rx ? recv_addr_ready : send_req_ready, 1);
      {recv_addr_valid, send_req_valid} <= 2'b00;
   endtask : offer
   // Drives one receive cycle.
   task automatic rx(logic v, logic [63:0] d, logic l);
      @(posedge sys_clk);
      net_rx_valid <= v;
      net_rx_flit <= '{data: d, last: l};
   endtask : rx
   // Sends an n-flit packet counting up from b; idle data is inverted.
   task automatic rx_pkt(int n, logic [63:0] b);
      for (int i = 0; i < n; i++) rx(1'b1, b + 64'(i), i == n - 1);
      rx(1'b0, ~b, 1'b0);
   endtask : rx_pkt
   // Pops n sent flits and compares them with memory from a upward.
   task automatic expect_tx(logic [31:0] a, int n);
      logic [31:0] x;
      for (int i = 0; i < n; i++) begin
         x = a + 32'(8 * i);
         f = far.tx_q.pop_front();
         check("tx flit", f, {x, ~x, i == n - 1});
      end
   endtask : expect_tx
   // Pops n memory writes of a packet counting up from b.
   task automatic expect_wr(logic [31:0] a, logic [63:0] b, int n);
      for (int i = 0; i < n; i++)
         check("write", far.wr_q.pop_front(),
               {a + 32'(8*i), b + 64'(i)});
   endtask : expect_wr
   // Waits for the completions, then reads them away one at a time.
   task automatic clear(int ns, int nr);
      repeat (300) if ({send_comp_count, recv_comp_count} !== {ns[3:0],
         nr[3:0]}) @(posedge sys_clk);
      check("counts", {send_comp_count, recv_comp_count},
            {ns[3:0], nr[3:0]});
      for (int k = 0; k < ns + nr; k++) begin
         @(posedge sys_clk);
         check("irq held", irq, 1'b1);
         send_comp_read <= (k < ns);
         recv_comp_read <= (k >= ns);
         @(posedge sys_clk);
         {send_comp_read, recv_comp_read} <= 2'b00;
      end
      repeat (2) @(posedge sys_clk);
      check("cleared", {irq, send_comp_count, recv_comp_count}, 0);
   endtask : clear
   // Twelve-flit send: tags wrap and each read is answered before the next one is taken; flits leave in issue order.
   task automatic t_send();
      offer(1'b0, 32'h0000_1000, 8'd12);
      wait_q(1'b0, 12);
      expect_tx(32'h0000_1000, 12);
      clear(1, 0);
   endtask : t_send
   // A three-flit packet is written at the supplied address.
   task automatic t_recv();
      offer(1'b1, 32'h0000_2000, 8'd0);
      rx_pkt(3, 64'h00AA_0000_0000_0000);
      wait_q(1'b1, 3);
      expect_wr(32'h0000_2000, 64'h00AA_0000_0000_0000, 3);
      clear(0, 1);
   endtask : t_recv
   // Past 3/4 full a pause frame goes out; a packet that no longer
   // fits is dropped whole while its neighbours survive.
   task automatic t_fill();
      rx_pkt(7, 64'h0011_0000_0000_0000);
      rx_pkt(7, 64'h0022_0000_0000_0000);
      wait_q(1'b0, 8);
      f = far.tx_q.pop_front();
      check("pause dest", f.data[47:0], NIC_PAUSE_MAC);
      f = far.tx_q.pop_front();
      check("pause type", f.data[63:32], NIC_PAUSE_TYPOP);
      for (int i = 2; i < 8; i++) begin
         f = far.tx_q.pop_front();
         check("pause end", f.last, i == 7);
      end
      rx_pkt(5, 64'h0033_0000_0000_0000);
      repeat (20) @(posedge sys_clk);
      check("no address", far.wr_q.size(), 0);
      offer(1'b1, 32'h0000_4000, 8'd0);
      offer(1'b1, 32'h0000_5000, 8'd0);
      wait_q(1'b1, 14);
      expect_wr(32'h0000_4000, 64'h0011_0000_0000_0000, 7);
      expect_wr(32'h0000_5000, 64'h0022_0000_0000_0000, 7);
      offer(1'b1, 32'h0000_6000, 8'd0);
      rx_pkt(2, 64'h0044_0000_0000_0000);
      wait_q(1'b1, 2);
      expect_wr(32'h0000_6000, 64'h0044_0000_0000_0000, 2);
      clear(0, 3);
   endtask : t_fill
   // A received pause frame holds the next send back for a while.
   task automatic t_pause();
      offer(1'b1, 32'h0000_7000, 8'd0);
      rx(1'b1, {16'h0000, NIC_PAUSE_MAC}, 1'b0);
      rx(1'b1, {NIC_PAUSE_TYPOP, 32'h0000_0000}, 1'b0);
      rx(1'b1, 64'h0000_0000_0000_0400, 1'b1);
      rx(1'b0, 64'hFFFF_FFFF_FFFF_FBFF, 1'b0);
      offer(1'b0, 32'h0000_3000, 8'd2);
      repeat (16) @(posedge sys_clk);
      check("paused", far.tx_q.size(), 0);
      wait_q(1'b0, 2);
      expect_tx(32'h0000_3000, 2);
      clear(1, 1);
   endtask : t_pause
   // Reset for two cycles, then run each scenario in turn.
   initial begin
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      check("reset", {irq, send_comp_count, recv_comp_count}, 0);
      t_send();
      t_recv();
      t_fill();
      t_pause();
      finish_test();
   end
   // Watchdog well beyond the expected run length.
   initial begin
      #1_200_000;
      failures++;
      finish_test();
   end
endmodule : nic_top_bench
`default_nettype wire
